/* prc_defs.vh */
// Constants for the reset controller: register offsets, fields, reset values, timing.
// Assumes a 250 MHz clock and a single AHB-Lite master.
// Function
// R1: Internal power-on reset brings the device up without any external reset.
// R2: Host holds the active-low reset input low at least 1 us.
// R3: Hardware reset restores all register defaults and re-latches the straps.
// R4: Writing one to control bit 15 starts a full software reset.
// R5: Full software reset completes about 1 us after the write.
// R6: Full software reset restores defaults but keeps the latched straps.
// R7: Host waits 3 us after a software reset before further management access.
// R8: Writing one to control-two bit 9 restarts transmit and receive datapaths.
// R9: Datapath reset keeps all registers and leaves them accessible.
// R10: Timesync reset bit clears the time clock, its logic and its registers.
// R11: Timesync reset leaves clock-output config and clock-source registers untouched.
// R12: Basic mode control register sits at offset 0x00, read-write.
// R13: Control register two sits at offset 0x1c on page 0.
// R14: Reset bits self-clear when done; no access during hardware or full reset.
`ifndef PRC_DEFS_VH
`define PRC_DEFS_VH

// Register indices (byte address = index * 4)
`define PRC_IDX_BMC      5'h00
`define PRC_IDX_PAGESEL  5'h13
`define PRC_IDX_CTL2     5'h1c
`define PRC_IDX_TSCTL    5'h14
`define PRC_IDX_COC      5'h15
`define PRC_IDX_CLKSRC   5'h16
`define PRC_IDX_STATUS   5'h17
`define PRC_IDX_STRAP    5'h18
`define PRC_PAGE_MAIN    3'h0
`define PRC_PAGE_TS      3'h4

// Fields
`define PRC_BMC_RST_BIT  15
`define PRC_CTL2_DP_BIT  9
`define PRC_TS_RST_BIT   0

// Reset values
`define PRC_BMC_DEF      16'h3100
`define PRC_CTL2_DEF     16'h0000
`define PRC_TSCTL_DEF    16'h0000
`define PRC_COC_DEF      16'h0000
`define PRC_CLKSRC_DEF   16'h0000

// Timing
`define PRC_CLK_MHZ      250
`define PRC_POR_NS       1000
`define PRC_HWRST_NS     1000
`define PRC_SWRST_NS     1000
`define PRC_DPRST_NS     100
`define PRC_TSRST_NS     100

`endif

/* prc_reset_ctrl.v */
// Reset controller for a single-port transceiver with a time-sync clock.
// AHB-Lite slave for management registers; straps and reset pin sync to mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"

module prc_reset_ctrl #(
   parameter STRAP_W = 8
) (
   // Clock and reset
   input  wire               mclk_i,
   input  wire               srst_i,
   // Device pins
   input  wire               hw_rst_n_i,
   input  wire [STRAP_W-1:0] strap_i,
   // AHB-Lite slave
   input  wire               hsel_i,
   input  wire [31:0]        haddr_i,
   input  wire [1:0]         htrans_i,
   input  wire               hwrite_i,
   input  wire [2:0]         hsize_i,
   input  wire [31:0]        hwdata_i,
   input  wire               hready_i,
   output wire [31:0]        hrdata_o,
   output wire               hreadyout_o,
   output wire               hresp_o,
   // Reset outputs and latched straps to the rest of the chip
   output reg                chip_rst_o,
   output reg                datapath_rst_o,
   output reg                timesync_rst_o,
   output reg  [STRAP_W-1:0] strap_cfg_o,
   // Configuration to the datapath and clock output
   output reg  [15:0]        basic_mode_control_reg_o,
   output reg  [15:0]        clock_output_config_reg_o,
   output reg  [15:0]        clock_source_select_reg_o
);

   // ****************************************************************
   // Timing counts
   // ****************************************************************
   localparam integer POR_CYC  = (`PRC_POR_NS * `PRC_CLK_MHZ + 999) / 1000;
   localparam integer HWR_CYC  = (`PRC_HWRST_NS * `PRC_CLK_MHZ + 999) / 1000;
   localparam integer SWR_CYC  = (`PRC_SWRST_NS * `PRC_CLK_MHZ + 999) / 1000;
   localparam integer DPR_CYC  = (`PRC_DPRST_NS * `PRC_CLK_MHZ + 999) / 1000;
   localparam integer TSR_CYC  = (`PRC_TSRST_NS * `PRC_CLK_MHZ + 999) / 1000;

   localparam [1:0] ST_POR  = 2'h0;
   localparam [1:0] ST_RUN  = 2'h1;
   localparam [1:0] ST_HRST = 2'h2;
   localparam [1:0] ST_SRST = 2'h3;

   // ****************************************************************
   // Reset pin filter and chip reset sequencing
   // ****************************************************************
   reg  [1:0]  state_r;
   reg  [9:0]  cnt_r;
   reg  [9:0]  low_cnt_r;
   reg         hw_req_r;
   reg         sw_req_r;
   reg  [7:0]  dp_cnt_r;
   reg  [7:0]  ts_cnt_r;
   reg         strap_pend_r;

   // Pin must stay low for the full minimum width before it counts
   always @(posedge mclk_i) begin
      if (srst_i) begin
         low_cnt_r <= 10'h000;
         hw_req_r  <= 1'b0;
      end else begin
         hw_req_r <= 1'b0;
         if (hw_rst_n_i)
            low_cnt_r <= 10'h000;
         else if (low_cnt_r != HWR_CYC[9:0]) begin
            low_cnt_r <= low_cnt_r + 10'h001;
            if (low_cnt_r == HWR_CYC[9:0] - 10'h001)
               hw_req_r <= 1'b1; // R2
         end
      end
   end

   always @(posedge mclk_i) begin
      if (srst_i) begin
         state_r      <= ST_POR; // R1
         cnt_r        <= 10'h000;
         strap_pend_r <= 1'b1;
      end else begin
         strap_pend_r <= 1'b0;
         case (state_r)
            ST_POR, ST_HRST: begin
               if (!hw_rst_n_i)
                  cnt_r <= 10'h000;
               else if (cnt_r == POR_CYC[9:0] - 10'h001) begin
                  state_r      <= ST_RUN;
                  strap_pend_r <= 1'b1; // R3
               end else
                  cnt_r <= cnt_r + 10'h001;
            end
            ST_RUN: begin
               cnt_r <= 10'h000;
               if (hw_req_r)
                  state_r <= ST_HRST;
               else if (sw_req_r)
                  state_r <= ST_SRST; // R4
            end
            ST_SRST: begin
               if (hw_req_r) begin
                  state_r <= ST_HRST;
                  cnt_r   <= 10'h000;
               end else if (cnt_r == SWR_CYC[9:0] - 10'h001)
                  state_r <= ST_RUN; // R5
               else
                  cnt_r <= cnt_r + 10'h001;
            end
            default: state_r <= ST_POR;
         endcase
      end
   end

   // Straps captured on release from power-on or hardware reset only
   always @(posedge mclk_i) begin
      if (srst_i)
         strap_cfg_o <= {STRAP_W{1'b0}};
      else if (strap_pend_r && state_r == ST_RUN)
         strap_cfg_o <= strap_i; // R3 R6
   end

   wire in_reset = (state_r != ST_RUN);

   always @(posedge mclk_i) begin
      if (srst_i)
         chip_rst_o <= 1'b1;
      else
         chip_rst_o <= in_reset;
   end

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   reg         dph_r;
   reg         dwr_r;
   reg  [4:0]  didx_r;
   reg  [31:0] rdata_r;
   reg  [2:0]  page_r;
   reg  [15:0] ctl2_r;
   reg  [15:0] tsctl_r;
   reg         rd_wait_r;

   // Stall while a chip-level reset runs so no access is lost or half done
   // A read right behind a landing write waits one cycle so it sees the new value
   assign hreadyout_o = !(dph_r && (in_reset || rd_wait_r)); // R14
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_r;

   wire take = hsel_i && htrans_i[1] && hready_i;
   wire wr   = dph_r && dwr_r && !in_reset;

   function [15:0] rd_mux;
      input [4:0] idx;
      input [2:0] pg;
      begin
         rd_mux = 16'h0000;
         if (idx == `PRC_IDX_BMC)
            rd_mux = basic_mode_control_reg_o; // R12
         else if (idx == `PRC_IDX_PAGESEL)
            rd_mux = {13'h0, pg};
         else if (idx == `PRC_IDX_CTL2 && pg == `PRC_PAGE_MAIN)
            rd_mux = ctl2_r; // R13
         else if (pg == `PRC_PAGE_TS) begin
            case (idx)
               `PRC_IDX_TSCTL:  rd_mux = tsctl_r;
               `PRC_IDX_COC:    rd_mux = clock_output_config_reg_o;
               `PRC_IDX_CLKSRC: rd_mux = clock_source_select_reg_o;
               `PRC_IDX_STATUS: rd_mux = {13'h0, timesync_rst_o,
                                          datapath_rst_o, in_reset};
               `PRC_IDX_STRAP:  rd_mux = {{(16-STRAP_W){1'b0}}, strap_cfg_o};
               default:         rd_mux = 16'h0000;
            endcase
         end
      end
   endfunction

   always @(posedge mclk_i) begin
      if (srst_i) begin
         dph_r   <= 1'b0;
         dwr_r   <= 1'b0;
         didx_r  <= 5'h00;
         rdata_r <= 32'h0000_0000;
         rd_wait_r <= 1'b0;
      end else begin
         if (hreadyout_o) begin
            dph_r  <= take;
            dwr_r  <= hwrite_i;
            didx_r <= haddr_i[6:2];
            rd_wait_r <= take && !hwrite_i && wr;
            if (take && !hwrite_i)
               rdata_r <= {16'h0000, rd_mux(haddr_i[6:2], page_r)};
         end else begin
            // Refetch while stalled so the data reflect the state at release
            rd_wait_r <= 1'b0;
            if (!dwr_r)
               rdata_r <= {16'h0000, rd_mux(didx_r, page_r)};
         end
      end
   end

   // ****************************************************************
   // Registers and partial resets
   // ****************************************************************
   // Full reset clears everything but the latched straps, timesync reset only its own control
   always @(posedge mclk_i) begin
      if (srst_i || in_reset) begin
         basic_mode_control_reg_o  <= `PRC_BMC_DEF; // R3 R6 R14
         ctl2_r                    <= `PRC_CTL2_DEF;
         tsctl_r                   <= `PRC_TSCTL_DEF;
         clock_output_config_reg_o <= `PRC_COC_DEF;
         clock_source_select_reg_o <= `PRC_CLKSRC_DEF;
         page_r                    <= `PRC_PAGE_MAIN;
         sw_req_r                  <= 1'b0;
         dp_cnt_r                  <= 8'h00;
         ts_cnt_r                  <= 8'h00;
         datapath_rst_o            <= 1'b0;
         timesync_rst_o            <= 1'b0;
      end else begin
         sw_req_r <= 1'b0;
         if (dp_cnt_r != 8'h00)
            dp_cnt_r <= dp_cnt_r - 8'h01;
         else if (datapath_rst_o) begin
            datapath_rst_o                 <= 1'b0;
            ctl2_r[`PRC_CTL2_DP_BIT]       <= 1'b0; // R14
         end
         if (ts_cnt_r != 8'h00)
            ts_cnt_r <= ts_cnt_r - 8'h01;
         else if (timesync_rst_o) begin
            timesync_rst_o <= 1'b0;
            tsctl_r        <= `PRC_TSCTL_DEF; // R10 R11
         end
         if (wr) begin
            if (didx_r == `PRC_IDX_BMC) begin
               basic_mode_control_reg_o <= hwdata_i[15:0];
               if (hwdata_i[`PRC_BMC_RST_BIT])
                  sw_req_r <= 1'b1; // R4
            end else if (didx_r == `PRC_IDX_PAGESEL)
               page_r <= hwdata_i[2:0];
            else if (didx_r == `PRC_IDX_CTL2 && page_r == `PRC_PAGE_MAIN) begin
               ctl2_r <= hwdata_i[15:0];
               if (hwdata_i[`PRC_CTL2_DP_BIT]) begin
                  datapath_rst_o <= 1'b1; // R8 R9
                  dp_cnt_r       <= DPR_CYC[7:0] - 8'h01;
               end
            end else if (page_r == `PRC_PAGE_TS) begin
               case (didx_r)
                  `PRC_IDX_TSCTL: begin
                     tsctl_r <= hwdata_i[15:0];
                     if (hwdata_i[`PRC_TS_RST_BIT]) begin
                        timesync_rst_o <= 1'b1; // R10
                        ts_cnt_r       <= TSR_CYC[7:0] - 8'h01;
                     end
                  end
                  `PRC_IDX_COC:    clock_output_config_reg_o <= hwdata_i[15:0];
                  `PRC_IDX_CLKSRC: clock_source_select_reg_o <= hwdata_i[15:0];
                  default: ;
               endcase
            end
         end
      end
   end

endmodule // prc_reset_ctrl
`default_nettype wire

/* prc_reset_ctrl_sva.sv */
// Port assertions for the reset controller.
// Assumes the reset pin stays high when srst_i is released.
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
module prc_reset_ctrl_sva #(parameter STRAP_W = 8) (
   input wire logic               mclk_i, srst_i, hw_rst_n_i, hsel_i, hwrite_i, hready_i,
   input wire logic [STRAP_W-1:0] strap_i, strap_cfg_o,
   input wire logic [31:0]        haddr_i, hwdata_i, hrdata_o,
   input wire logic [1:0]         htrans_i,
   input wire logic [2:0]         hsize_i,
   input wire logic               hreadyout_o, hresp_o, chip_rst_o, datapath_rst_o,
   input wire logic               timesync_rst_o,
   input wire logic [15:0]        basic_mode_control_reg_o, clock_output_config_reg_o,
   input wire logic [15:0]        clock_source_select_reg_o
);
   // ****
   // Pulse length counters
   // ****
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   logic [9:0] dp_n, ts_n, cr_n;
   always @(posedge mclk_i) begin
      dp_n <= (srst_i || !datapath_rst_o) ? 10'h0 : dp_n + 10'h1;
      ts_n <= (srst_i || !timesync_rst_o) ? 10'h0 : ts_n + 10'h1;
      cr_n <= (srst_i || !chip_rst_o) ? 10'h0 : (cr_n == 10'h3ff) ? cr_n : cr_n + 10'h1;
   end
   // Write data phase seen on the bus, to excuse the one wait after it
   logic wdp_q;
   always @(posedge mclk_i)
      if (srst_i) wdp_q <= 1'b0;
      else if (hreadyout_o) wdp_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
   sequence sw_start_s; $rose(basic_mode_control_reg_o[15]); endsequence
   sequence dp_hold_s; !chip_rst_o [*8]; endsequence
   por_release_a: assert property ($fell(srst_i) && hw_rst_n_i |-> ##[1:260] !chip_rst_o)
      else $error("power-on reset did not end");
   sw_start_a: assert property (sw_start_s |-> ##[0:3] chip_rst_o)
      else $error("software reset did not start");
   sw_length_a: assert property (sw_start_s |-> ##[250:262] !chip_rst_o)
      else $error("software reset too long");
   rst_min_a: assert property ($fell(chip_rst_o) |-> cr_n >= 10'd250)
      else $error("chip reset too short");
   def_after_a: assert property ($fell(chip_rst_o) |-> basic_mode_control_reg_o == `PRC_BMC_DEF)
      else $error("control register not at default after reset");
   dp_len_a: assert property ($fell(datapath_rst_o) |-> dp_n == 10'd25)
      else $error("datapath reset length wrong");
   dp_keep_a: assert property ($rose(datapath_rst_o) |-> dp_hold_s)
      else $error("datapath reset disturbed chip");
   ts_len_a: assert property ($fell(timesync_rst_o) |-> ts_n == 10'd25)
      else $error("timesync reset length wrong");
   ts_keep_a: assert property (timesync_rst_o |=> $stable(clock_output_config_reg_o)
      && $stable(clock_source_select_reg_o))
      else $error("clock output config changed in timesync reset");
   stall_only_a: assert property (!hreadyout_o |-> chip_rst_o || $past(chip_rst_o)
      || $past(wdp_q && hsel_i && htrans_i[1] && hready_i && !hwrite_i && hreadyout_o))
      else $error("bus stalled outside reset");
endmodule // prc_reset_ctrl_sva
bind prc_reset_ctrl prc_reset_ctrl_sva #(.STRAP_W(STRAP_W)) prc_reset_ctrl_sva_i (.mclk_i,
   .srst_i, .hw_rst_n_i, .hsel_i, .hwrite_i, .hready_i, .strap_i, .strap_cfg_o, .haddr_i,
   .hwdata_i, .hrdata_o, .htrans_i, .hsize_i, .hreadyout_o, .hresp_o, .chip_rst_o,
   .datapath_rst_o, .timesync_rst_o, .basic_mode_control_reg_o, .clock_output_config_reg_o,
   .clock_source_select_reg_o);
`default_nettype wire

/* prc_pin_host.sv */
// Host side of the reset pin: holds it low for a commanded count.
// Assumes go_i is a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module prc_pin_host (
   input  wire logic       mclk_i,
   input  wire logic       go_i,
   input  wire logic [9:0] len_i,
   output wire logic       hw_rst_n_o
);
   logic [9:0] left_r = 10'h0;
   always @(posedge mclk_i) left_r <= go_i ? len_i : (left_r != 10'h0) ? left_r - 10'h1 : 10'h0;
   // Pull-up level when released
   assign hw_rst_n_o = (left_r == 10'h0);
endmodule // prc_pin_host
`default_nettype wire

/* phy_reset_control_test.sv */
// Self-checking bench for the reset controller.
// Assumes a single AHB-Lite master and the pin host model.
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
module phy_reset_control_test;
   logic        mclk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, go = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
   logic [1:0]  htrans_i = 0;
   logic [7:0]  strap_i = 0, strap_cfg_o, s0;
   logic [15:0] bmc_o, coc_o, src_o, v, u;
   logic [9:0]  len = 0;
   logic        hreadyout_o, hresp_o, chip_rst_o, dp_rst_o, ts_rst_o, hw_rst_n;
   int          failures = 0, n_compared = 0;
   initial forever #2 mclk_i = ~mclk_i;
   prc_pin_host prc_pin_host_i (.mclk_i, .go_i(go), .len_i(len), .hw_rst_n_o(hw_rst_n));
   prc_reset_ctrl prc_reset_ctrl_i (.mclk_i, .srst_i, .hw_rst_n_i(hw_rst_n), .strap_i, .hsel_i,
      .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
      .hrdata_o, .hreadyout_o, .hresp_o, .chip_rst_o, .datapath_rst_o(dp_rst_o),
      .timesync_rst_o(ts_rst_o), .strap_cfg_o, .basic_mode_control_reg_o(bmc_o),
      .clock_output_config_reg_o(coc_o), .clock_source_select_reg_o(src_o));
   // ****
   // Bus and check tasks
   // ****
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Sample at the falling edge so the ready seen is the one the rising edge takes
   task phase;
      logic r;
      do begin
         @(negedge mclk_i);
         r = hreadyout_o;
         rd = hrdata_o;
         @(posedge mclk_i);
      end while (r !== 1'b1);
   endtask
   task xfer(input logic w, input logic [4:0] idx, input logic [15:0] d);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i <= {25'h0, idx, 2'h0};
      phase;
      htrans_i <= 2'h0;
      hwdata_i <= {16'h0, d};
      phase;
   endtask
   task rdchk(input logic [4:0] idx, input logic [15:0] e);
      xfer(1'b0, idx, 16'h0);
      chk(rd, {16'h0, e});
   endtask
   task settle(input int n);
      int k;
      repeat (n) @(posedge mclk_i);
      for (k = 0; k < 3000 && chip_rst_o !== 1'b0; k++) @(posedge mclk_i);
      if (k == 3000) failures++;
   endtask
   task test_done;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #80000;
      failures++;
      test_done;
   end
   initial begin
      void'($urandom(70272));
      s0 = 8'($urandom);
      strap_i <= s0;
      repeat (6) @(posedge mclk_i);
      srst_i <= 1'b0;
      settle(4);
      chk(strap_cfg_o, s0);
      rdchk(`PRC_IDX_BMC, `PRC_BMC_DEF);
      rdchk(`PRC_IDX_CTL2, `PRC_CTL2_DEF);
      rdchk(5'h05, 16'h0);
      v = 16'($urandom) & 16'h7fff;
      xfer(1'b1, `PRC_IDX_BMC, v);
      rdchk(`PRC_IDX_BMC, v);
      xfer(1'b1, `PRC_IDX_CTL2, 16'h0200);
      rdchk(`PRC_IDX_BMC, v);
      chk(dp_rst_o, 1'b1);
      repeat (30) @(posedge mclk_i);
      rdchk(`PRC_IDX_CTL2, 16'h0);
      xfer(1'b1, `PRC_IDX_PAGESEL, {13'h0, `PRC_PAGE_TS});
      v = 16'($urandom);
      u = 16'($urandom);
      xfer(1'b1, `PRC_IDX_COC, v);
      xfer(1'b1, `PRC_IDX_CLKSRC, u);
      xfer(1'b1, `PRC_IDX_TSCTL, 16'h0001);
      rdchk(`PRC_IDX_STATUS, 16'h0004);
      chk(ts_rst_o, 1'b1);
      repeat (30) @(posedge mclk_i);
      rdchk(`PRC_IDX_TSCTL, `PRC_TSCTL_DEF);
      rdchk(`PRC_IDX_COC, v);
      rdchk(`PRC_IDX_CLKSRC, u);
      chk(src_o, u);
      chk(hresp_o, 1'b0);
      strap_i <= ~s0;
      xfer(1'b1, `PRC_IDX_BMC, 16'h8000);
      repeat (750) @(posedge mclk_i);
      chk(strap_cfg_o, s0);
      chk(coc_o, `PRC_COC_DEF);
      rdchk(`PRC_IDX_PAGESEL, 16'h0);
      xfer(1'b1, `PRC_IDX_BMC, 16'h0100);
      len <= 10'd300;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      settle(300);
      chk(strap_cfg_o, {24'h0, ~s0});
      chk(bmc_o, `PRC_BMC_DEF);
      test_done;
   end
endmodule // phy_reset_control_test
`default_nettype wire
